// file: design/ship_standby_power_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
module ship_standby_power_mode_control #(
	parameter int MS_CYCLES = shelf_pkg::MS_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic key_reset_in_n,
	input wire logic reverse_boost_en,
	input wire shelf_pkg::sense_t sense,
	input wire logic [3:0] thermistor_sense,
	output shelf_pkg::power_out_t pwr,
	output logic [3:0] therm_state
);
	localparam int TW = shelf_pkg::TW;

	// Input deglitch
	logic [1:0] dg_raw;
	logic [1:0] dg_filt_r;
	logic [1:0] dg_filt_nxt;
	logic [8:0] dg_cnt_r [2];
	logic [8:0] dg_cnt_nxt [2];
	logic key_f;
	logic boost_f;

	assign dg_raw = {reverse_boost_en, key_reset_in_n};
	assign key_f = dg_filt_r[0];
	assign boost_f = dg_filt_r[1];

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			dg_filt_nxt[i] = dg_filt_r[i];
			dg_cnt_nxt[i] = 9'h000;
			if (dg_raw[i] != dg_filt_r[i]) begin
				if (dg_cnt_r[i] == 9'(shelf_pkg::GLITCH_CYCLES - 1)) begin
					dg_filt_nxt[i] = dg_raw[i];
				end else begin
					dg_cnt_nxt[i] = dg_cnt_r[i] + 9'h001;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dg_filt_r <= 2'h1;
			dg_cnt_r <= '{9'h000, 9'h000};
		end else begin
			dg_filt_r <= dg_filt_nxt;
			dg_cnt_r <= dg_cnt_nxt;
		end
	end

	// Free-running millisecond timebase
	logic [15:0] tb_cnt_r;
	logic [15:0] tb_cnt_nxt;
	logic ms_tick;

	always_comb begin
		ms_tick = (tb_cnt_r == 16'(MS_CYCLES - 1));
		tb_cnt_nxt = ms_tick ? 16'h0000 : tb_cnt_r + 16'h0001;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tb_cnt_r <= 16'h0000;
		end else begin
			tb_cnt_r <= tb_cnt_nxt;
		end
	end

	// Thermistor threshold filter
	logic [3:0] therm_acc_r;
	logic [3:0] therm_acc_nxt;
	logic [3:0] therm_cnt_r [4];
	logic [3:0] therm_cnt_nxt [4];

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			therm_acc_nxt[i] = therm_acc_r[i];
			therm_cnt_nxt[i] = therm_cnt_r[i];
			if (thermistor_sense[i] == therm_acc_r[i]) begin
				therm_cnt_nxt[i] = 4'h0;
			end else if (ms_tick) begin
				if (therm_cnt_r[i] == shelf_pkg::THERM_DEG_MS - 4'h1) begin
					therm_acc_nxt[i] = thermistor_sense[i];
					therm_cnt_nxt[i] = 4'h0;
				end else begin
					therm_cnt_nxt[i] = therm_cnt_r[i] + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			therm_acc_r <= 4'h0;
			therm_cnt_r <= '{4'h0, 4'h0, 4'h0, 4'h0};
		end else begin
			therm_acc_r <= therm_acc_nxt;
			therm_cnt_r <= therm_cnt_nxt;
		end
	end

	assign therm_state = therm_acc_r;

	// Mode sequencer
	shelf_pkg::state_t state_r;
	shelf_pkg::state_t state_nxt;
	shelf_pkg::ctrl0_t ctrl0_r;
	shelf_pkg::ctrl0_t ctrl0_nxt;
	shelf_pkg::ctrl1_t ctrl1_r;
	shelf_pkg::ctrl1_t ctrl1_nxt;
	logic [TW-1:0] tmr_r;
	logic [TW-1:0] tmr_nxt;
	logic [TW-1:0] key_cnt_r;
	logic [TW-1:0] key_cnt_nxt;
	logic [TW-1:0] wd_cnt_r;
	logic [TW-1:0] wd_cnt_nxt;
	logic entry_ok;
	logic bus_ok;
	logic wd_kick;
	logic [TW-1:0] key_exit_ms;

	// Host interface closed in ship mode
	assign bus_ok = (state_r != shelf_pkg::ST_SHIP) && (state_r != shelf_pkg::ST_POR);
	assign wd_kick = bus_ok && wr && (addr == shelf_pkg::ADDR_WD_KICK);
	assign entry_ok = ctrl0_r.ship_req && sense.supply_below_fall && key_f;
	assign key_exit_ms = ctrl0_r.key_wake_fast_sel ? shelf_pkg::KEY_EXIT_FAST_MS : shelf_pkg::KEY_EXIT_SLOW_MS;

	always_comb begin
		state_nxt = state_r;
		tmr_nxt = tmr_r;
		key_cnt_nxt = key_cnt_r;
		wd_cnt_nxt = wd_cnt_r;
		// Key low duration
		if (key_f) begin
			key_cnt_nxt = '0;
		end else if (ms_tick) begin
			key_cnt_nxt = key_cnt_r + 18'h0_0001;
		end
		// Watchdog runs while enabled in active mode only
		if (wd_kick || !ctrl1_r.watchdog_en || state_r != shelf_pkg::ST_ACTIVE) begin
			wd_cnt_nxt = '0;
		end else if (ms_tick) begin
			wd_cnt_nxt = wd_cnt_r + 18'h0_0001;
		end
		unique case (state_r)
			shelf_pkg::ST_POR: begin
				tmr_nxt = '0;
				if (sense.supply_above_rise || sense.battery_above_rise) begin
					state_nxt = shelf_pkg::ST_ACTIVE;
				end
			end
			shelf_pkg::ST_ACTIVE: begin
				tmr_nxt = '0;
				if (key_cnt_r >= shelf_pkg::PRESS_MS[ctrl1_r.long_press_time_sel]) begin
					state_nxt = shelf_pkg::ST_HW_RESET;
					key_cnt_nxt = '0;
				end else if (ctrl1_r.watchdog_en &&
						wd_cnt_r >= shelf_pkg::WD_MS[ctrl1_r.watchdog_timeout_sel]) begin
					state_nxt = shelf_pkg::ST_WD_OFF;
				end else if (ctrl0_r.ship_req) begin
					state_nxt = shelf_pkg::ST_SHIP_WAIT;
				end
			end
			shelf_pkg::ST_SHIP_WAIT: begin
				if (key_cnt_r >= shelf_pkg::PRESS_MS[ctrl1_r.long_press_time_sel]) begin
					state_nxt = shelf_pkg::ST_HW_RESET;
					key_cnt_nxt = '0;
					tmr_nxt = '0;
				end else if (!ctrl0_r.ship_req) begin
					state_nxt = shelf_pkg::ST_ACTIVE;
					tmr_nxt = '0;
				end else if (!entry_ok) begin
					// Postponed while supply or key present
					tmr_nxt = '0;
				end else if (ctrl0_r.shelf_entry_delay_off) begin
					state_nxt = shelf_pkg::ST_SHIP;
					tmr_nxt = '0;
				end else if (tmr_r >= shelf_pkg::ENTRY_DELAY_MS[ctrl0_r.shelf_entry_delay_sel]) begin
					state_nxt = shelf_pkg::ST_SHIP;
					tmr_nxt = '0;
				end else if (ms_tick) begin
					tmr_nxt = tmr_r + 18'h0_0001;
				end
			end
			shelf_pkg::ST_SHIP: begin
				if (!sense.supply_above_rise) begin
					tmr_nxt = '0;
				end else if (ms_tick) begin
					tmr_nxt = tmr_r + 18'h0_0001;
				end
				if (sense.supply_above_rise &&
						tmr_r >= shelf_pkg::SUPPLY_DEB_MS[ctrl0_r.supply_debounce_sel]) begin
					state_nxt = shelf_pkg::ST_ACTIVE;
					tmr_nxt = '0;
				end else if (!key_f && key_cnt_r >= key_exit_ms) begin
					state_nxt = shelf_pkg::ST_ACTIVE;
					tmr_nxt = '0;
					key_cnt_nxt = '0;
				end
			end
			shelf_pkg::ST_HW_RESET, shelf_pkg::ST_WD_OFF: begin
				if (tmr_r >= shelf_pkg::OFF_MS[ctrl1_r.power_off_time_sel]) begin
					state_nxt = shelf_pkg::ST_POR;
					tmr_nxt = '0;
				end else if (ms_tick) begin
					tmr_nxt = tmr_r + 18'h0_0001;
				end
			end
			default: begin
				state_nxt = shelf_pkg::ST_POR;
				tmr_nxt = '0;
			end
		endcase
	end

	// Register file
	always_comb begin
		ctrl0_nxt = ctrl0_r;
		ctrl1_nxt = ctrl1_r;
		if (bus_ok && wr && addr == shelf_pkg::ADDR_CTRL0) begin
			ctrl0_nxt = wdata;
		end
		if (bus_ok && wr && addr == shelf_pkg::ADDR_CTRL1) begin
			ctrl1_nxt = wdata;
			ctrl1_nxt.reserved = 1'b0;
		end
		// Fast wake restored to default on exit
		if (state_r == shelf_pkg::ST_SHIP && state_nxt != shelf_pkg::ST_SHIP) begin
			ctrl0_nxt.key_wake_fast_sel = shelf_pkg::CTRL0_RST.key_wake_fast_sel;
			ctrl0_nxt.ship_req = 1'b0;
		end
	end

	shelf_pkg::status_t status;
	logic [7:0] rdata_nxt;

	always_comb begin
		status.mode = state_r;
		status.therm = therm_acc_r;
		status.standby = pwr.standby_mode;
		rdata_nxt = 8'h00;
		if (bus_ok && rd) begin
			unique case (addr)
				shelf_pkg::ADDR_CTRL0: rdata_nxt = ctrl0_r;
				shelf_pkg::ADDR_CTRL1: rdata_nxt = ctrl1_r;
				shelf_pkg::ADDR_STATUS: rdata_nxt = status;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	// Power outputs
	shelf_pkg::power_out_t pwr_nxt;
	logic sys_up;

	always_comb begin
		sys_up = (state_nxt == shelf_pkg::ST_ACTIVE) || (state_nxt == shelf_pkg::ST_SHIP_WAIT);
		// Battery switch closed while the system is up with battery or supply up
		pwr_nxt.battery_switch_on = sys_up && (sense.battery_above_rise || sense.supply_above_rise);
		pwr_nxt.host_if_ready = (state_nxt != shelf_pkg::ST_SHIP) && (state_nxt != shelf_pkg::ST_POR);
		pwr_nxt.standby_mode = sys_up && !sense.supply_above_rise && !sense.system_load;
		// Boost from pin, stopped on overvoltage
		pwr_nxt.boost_run = sys_up && boost_f && !sense.mid_overvoltage;
		pwr_nxt.low_power_regs_en = pwr_nxt.boost_run;
		// Reverse path gated by its bit
		pwr_nxt.reverse_path_closed = pwr_nxt.boost_run && ctrl0_r.reverse_output_path_en;
		pwr_nxt.reference_regulator_on = sys_up && sense.supply_above_rise && !pwr_nxt.boost_run;
		pwr_nxt.system_rail_off = !sys_up;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= shelf_pkg::ST_POR;
			tmr_r <= '0;
			key_cnt_r <= '0;
			wd_cnt_r <= '0;
			ctrl0_r <= shelf_pkg::CTRL0_RST;
			ctrl1_r <= shelf_pkg::CTRL1_RST;
			rdata <= 8'h00;
			pwr <= shelf_pkg::PWR_RST;
		end else begin
			state_r <= state_nxt;
			tmr_r <= tmr_nxt;
			key_cnt_r <= key_cnt_nxt;
			wd_cnt_r <= wd_cnt_nxt;
			ctrl0_r <= ctrl0_nxt;
			ctrl1_r <= ctrl1_nxt;
			rdata <= rdata_nxt;
			pwr <= pwr_nxt;
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	ship_entry_gate_a: assert property (
		(state_r == shelf_pkg::ST_SHIP_WAIT && state_nxt == shelf_pkg::ST_SHIP) |-> entry_ok)
		else $error("ship entered without entry conditions");
	ship_delay_wait_a: assert property (
		(state_r == shelf_pkg::ST_SHIP_WAIT && state_nxt == shelf_pkg::ST_SHIP && !ctrl0_r.shelf_entry_delay_off)
		|-> tmr_r >= shelf_pkg::ENTRY_DELAY_MS[ctrl0_r.shelf_entry_delay_sel])
		else $error("ship entered before entry delay");
	delay_skip_a: assert property (
		(state_r == shelf_pkg::ST_SHIP_WAIT && entry_ok && ctrl0_r.shelf_entry_delay_off && key_cnt_r == '0)
		|=> state_r == shelf_pkg::ST_SHIP)
		else $error("delay off did not enter at once");
	entry_restart_a: assert property (
		(state_r == shelf_pkg::ST_SHIP_WAIT && !entry_ok) |=> tmr_r == '0)
		else $error("entry delay not restarted");
	ship_bus_closed_a: assert property (
		(state_r == shelf_pkg::ST_SHIP && state_nxt == shelf_pkg::ST_SHIP && (rd || wr))
		|=> rdata == 8'h00 && $stable(ctrl0_r) && $stable(ctrl1_r))
		else $error("register access serviced in ship mode");
	fast_wake_restore_a: assert property (
		(state_r == shelf_pkg::ST_SHIP && state_nxt != shelf_pkg::ST_SHIP) |=> !ctrl0_r.key_wake_fast_sel)
		else $error("fast wake bit not restored");
	key_wake_time_a: assert property (
		(state_r == shelf_pkg::ST_SHIP && state_nxt == shelf_pkg::ST_ACTIVE && !sense.supply_above_rise)
		|-> key_cnt_r >= key_exit_ms)
		else $error("key wake too early");
	off_hold_a: assert property (
		$rose(state_r == shelf_pkg::ST_HW_RESET) |-> pwr.system_rail_off && !pwr.battery_switch_on)
		else $error("system not off during reset");
	wd_expire_a: assert property (
		(state_r == shelf_pkg::ST_ACTIVE && state_nxt == shelf_pkg::ST_WD_OFF)
		|-> wd_cnt_r >= shelf_pkg::WD_MS[ctrl1_r.watchdog_timeout_sel])
		else $error("watchdog expired early");
	boost_ovp_a: assert property (
		sense.mid_overvoltage |=> !pwr.boost_run && !pwr.reverse_path_closed)
		else $error("boost running through overvoltage");
	reverse_path_a: assert property (
		pwr.reverse_path_closed |-> pwr.boost_run && $past(ctrl0_r.reverse_output_path_en))
		else $error("reverse path closed without enable");
	glitch_reject_a: assert property (
		$changed(key_f) |-> $past(dg_cnt_r[0]) == 9'(shelf_pkg::GLITCH_CYCLES - 1))
		else $error("key filter changed early");
	supply_wake_time_a: assert property (
		(state_r == shelf_pkg::ST_SHIP && state_nxt == shelf_pkg::ST_ACTIVE && key_f)
		|-> tmr_r >= shelf_pkg::SUPPLY_DEB_MS[ctrl0_r.supply_debounce_sel])
		else $error("supply wake too early");
	off_hold_time_a: assert property (
		((state_r == shelf_pkg::ST_HW_RESET || state_r == shelf_pkg::ST_WD_OFF) && state_nxt == shelf_pkg::ST_POR)
		|-> tmr_r >= shelf_pkg::OFF_MS[ctrl1_r.power_off_time_sel])
		else $error("power off hold too short");
	therm_accept_a: assert property (
		(therm_acc_nxt[0] != therm_acc_r[0])
		|-> ms_tick && therm_cnt_r[0] == shelf_pkg::THERM_DEG_MS - 4'h1)
		else $error("thermistor crossing taken early");
	power_up_a: assert property (
		(state_r == shelf_pkg::ST_POR && (sense.supply_above_rise || sense.battery_above_rise))
		|=> pwr.host_if_ready && pwr.battery_switch_on)
		else $error("no readiness after power up");
	standby_entry_a: assert property (
		(state_nxt == shelf_pkg::ST_ACTIVE && sense.battery_above_rise && !sense.supply_above_rise && !sense.system_load)
		|=> pwr.standby_mode && pwr.battery_switch_on)
		else $error("standby not entered on battery");
	boost_regs_a: assert property (
		(state_r == shelf_pkg::ST_ACTIVE && state_nxt == shelf_pkg::ST_ACTIVE && boost_f && !sense.mid_overvoltage)
		|=> pwr.boost_run && pwr.low_power_regs_en)
		else $error("boost or regulators not enabled");
endmodule : ship_standby_power_mode_control
`default_nettype wire

// file: design/shelf_pkg.sv
package shelf_pkg;
	// Timebase
	localparam int CLK_PERIOD_NS = 32'h0000_0019;
	localparam int MS_NS = 32'h000F_4240;
	localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
	localparam int GLITCH_NS = 32'h0000_2710;
	localparam int GLITCH_CYCLES = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TW = 18;
	// Millisecond tables indexed by select fields
	localparam logic [TW-1:0] ENTRY_DELAY_MS [4] = '{18'h0_07d0, 18'h0_0fa0, 18'h0_1b58, 18'h0_2710};
	localparam logic [TW-1:0] SUPPLY_DEB_MS [4] = '{18'h0_000a, 18'h0_0014, 18'h0_0064, 18'h0_00c8};
	localparam logic [TW-1:0] PRESS_MS [4] = '{18'h0_0fa0, 18'h0_1f40, 18'h0_2ee0, 18'h0_4e20};
	localparam logic [TW-1:0] OFF_MS [4] = '{18'h0_03e8, 18'h0_07d0, 18'h0_0bb8, 18'h0_0fa0};
	localparam logic [TW-1:0] WD_MS [4] = '{18'h0_9c40, 18'h1_3880, 18'h2_7100, 18'h2_7100};
	localparam logic [TW-1:0] KEY_EXIT_SLOW_MS = 18'h0_07d0;
	localparam logic [TW-1:0] KEY_EXIT_FAST_MS = 18'h0_0014;
	localparam logic [3:0] THERM_DEG_MS = 4'ha;
	// Register map
	localparam logic [7:0] ADDR_CTRL0 = 8'h00;
	localparam logic [7:0] ADDR_CTRL1 = 8'h01;
	localparam logic [7:0] ADDR_WD_KICK = 8'h02;
	localparam logic [7:0] ADDR_STATUS = 8'h03;
	typedef struct packed {
		logic reverse_output_path_en;
		logic [1:0] supply_debounce_sel;
		logic key_wake_fast_sel;
		logic shelf_entry_delay_off;
		logic [1:0] shelf_entry_delay_sel;
		logic ship_req;
	} ctrl0_t;
	typedef struct packed {
		logic reserved;
		logic watchdog_en;
		logic [1:0] watchdog_timeout_sel;
		logic [1:0] power_off_time_sel;
		logic [1:0] long_press_time_sel;
	} ctrl1_t;
	localparam ctrl0_t CTRL0_RST = 8'h40;
	localparam ctrl1_t CTRL1_RST = 8'h00;
	typedef enum logic [2:0] {
		ST_POR = 3'b000,
		ST_ACTIVE = 3'b001,
		ST_SHIP_WAIT = 3'b010,
		ST_SHIP = 3'b011,
		ST_HW_RESET = 3'b100,
		ST_WD_OFF = 3'b101
	} state_t;
	typedef struct packed {
		logic [2:0] mode;
		logic [3:0] therm;
		logic standby;
	} status_t;
	// Analog comparator flags
	typedef struct packed {
		logic supply_above_rise;
		logic supply_below_fall;
		logic battery_above_rise;
		logic system_load;
		logic mid_overvoltage;
	} sense_t;
	typedef struct packed {
		logic battery_switch_on;
		logic host_if_ready;
		logic reference_regulator_on;
		logic standby_mode;
		logic boost_run;
		logic low_power_regs_en;
		logic reverse_path_closed;
		logic system_rail_off;
	} power_out_t;
	localparam power_out_t PWR_RST = 8'h01;
endpackage : shelf_pkg

// file: tb/key_supply_model.sv
`timescale 1ns/1ps
`default_nettype none
module key_supply_model (
	input wire logic press,
	input wire logic plug,
	input wire logic ovp,
	output logic key_reset_in_n,
	output shelf_pkg::sense_t sense
);
	// Key line pulled up while released
	assign key_reset_in_n = !press;
	// Supply flags follow the plug, battery always up
	always_comb begin
		sense.supply_above_rise = plug;
		sense.supply_below_fall = !plug;
		sense.battery_above_rise = 1'b1;
		sense.system_load = 1'b0;
		sense.mid_overvoltage = ovp;
	end
endmodule : key_supply_model
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int MS = 10;
	logic clk, rst_n, wr, rd, press, plug, ovp, boost_en;
	logic [7:0] addr, wdata, rdata, d;
	logic [3:0] therm_in, therm_state;
	logic key_n;
	shelf_pkg::sense_t sense;
	shelf_pkg::power_out_t pwr;
	int failures, n_compared;

	ship_standby_power_mode_control #(.MS_CYCLES(MS)) i_ship_standby_power_mode_control (
		.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.key_reset_in_n(key_n), .reverse_boost_en(boost_en), .sense(sense),
		.thermistor_sense(therm_in), .pwr(pwr), .therm_state(therm_state));
	key_supply_model i_key_supply_model (.press(press), .plug(plug), .ovp(ovp),
		.key_reset_in_n(key_n), .sense(sense));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : cyc

	task automatic ms(input int n);
		cyc(n * MS);
	endtask : ms

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask : rd_reg

	task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
		rd_reg(a, d);
		chk(n, e, d);
	endtask : rchk

	task automatic chk_up(input logic e);
		chk("host_if_ready", {7'h00, e}, {7'h00, pwr.host_if_ready});
		chk("system_rail_off", {7'h00, !e}, {7'h00, pwr.system_rail_off});
	endtask : chk_up

	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done

	initial begin
		repeat (32'h0002_0000) @(posedge clk);
		failures++;
		test_done();
	end

	initial begin
		rst_n = 1'b0;
		{wr, rd, press, plug, ovp, boost_en} = 6'h00;
		addr = 8'h00;
		wdata = 8'h00;
		therm_in = 4'h0;
		cyc(2);
		chk("pwr_in_reset", 8'h01, pwr);
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		cyc(3);
		chk_up(1'b1);
		chk("battery_switch", 8'h01, {7'h00, pwr.battery_switch_on});
		chk("reference_reg", 8'h00, {7'h00, pwr.reference_regulator_on});
		chk("standby", 8'h01, {7'h00, pwr.standby_mode});
		rchk("ctrl0", shelf_pkg::ADDR_CTRL0, 8'h40);
		rchk("ctrl1", shelf_pkg::ADDR_CTRL1, 8'h00);
		rchk("unmapped", 8'h7f, 8'h00);
		wr_reg(shelf_pkg::ADDR_CTRL1, 8'hff);
		rchk("ctrl1_rw", shelf_pkg::ADDR_CTRL1, 8'h7f);
		wr_reg(shelf_pkg::ADDR_CTRL1, 8'h00);
		// Immediate entry with the delay switched off
		wr_reg(shelf_pkg::ADDR_CTRL0, 8'h49);
		cyc(5);
		chk_up(1'b0);
		chk("battery_switch", 8'h00, {7'h00, pwr.battery_switch_on});
		rchk("ship_read", shelf_pkg::ADDR_CTRL0, 8'h00);
		wr_reg(shelf_pkg::ADDR_CTRL1, 8'h03);
		// Exit by supply after the default debounce
		@(posedge clk) plug <= 1'b1;
		ms(90);
		chk_up(1'b0);
		ms(20);
		chk_up(1'b1);
		rchk("ctrl0_exit", shelf_pkg::ADDR_CTRL0, 8'h48);
		chk("reference_reg_usb", 8'h01, {7'h00, pwr.reference_regulator_on});
		chk("standby_usb", 8'h00, {7'h00, pwr.standby_mode});
		rchk("ctrl1_kept", shelf_pkg::ADDR_CTRL1, 8'h00);
		// Entry postponed by supply, restarted by a key press
		wr_reg(shelf_pkg::ADDR_CTRL0, 8'h51);
		ms(10);
		rd_reg(shelf_pkg::ADDR_STATUS, d);
		chk("mode_wait", 8'h02, {5'h00, d[7:5]});
		@(posedge clk) plug <= 1'b0;
		ms(1000);
		@(posedge clk) press <= 1'b1;
		ms(100);
		@(posedge clk) press <= 1'b0;
		ms(1900);
		rd_reg(shelf_pkg::ADDR_STATUS, d);
		chk("mode_restart", 8'h02, {5'h00, d[7:5]});
		ms(250);
		chk_up(1'b0);
		// Fast key exit
		@(posedge clk) press <= 1'b1;
		ms(30);
		chk_up(1'b0);
		ms(50);
		chk_up(1'b1);
		@(posedge clk) press <= 1'b0;
		rchk("ctrl0_fast_clr", shelf_pkg::ADDR_CTRL0, 8'h40);
		// Boost pin, short pulse first
		@(posedge clk) boost_en <= 1'b1;
		cyc(200);
		@(posedge clk) boost_en <= 1'b0;
		cyc(500);
		chk("boost_glitch", 8'h00, {7'h00, pwr.boost_run});
		@(posedge clk) boost_en <= 1'b1;
		ms(45);
		chk("boost_run", 8'h01, {7'h00, pwr.boost_run});
		chk("low_power_regs", 8'h01, {7'h00, pwr.low_power_regs_en});
		chk("path_open", 8'h00, {7'h00, pwr.reverse_path_closed});
		wr_reg(shelf_pkg::ADDR_CTRL0, 8'hc0);
		cyc(3);
		chk("path_closed", 8'h01, {7'h00, pwr.reverse_path_closed});
		@(posedge clk) ovp <= 1'b1;
		cyc(3);
		chk("boost_ovp", 8'h00, {7'h00, pwr.boost_run});
		@(posedge clk) begin
			ovp <= 1'b0;
			boost_en <= 1'b0;
			therm_in <= 4'h5;
		end
		ms(5);
		chk("therm_early", 8'h00, {4'h0, therm_state});
		ms(10);
		chk("therm_taken", 8'h05, {4'h0, therm_state});
		// Long press with shortest press and off times
		@(posedge clk) press <= 1'b1;
		ms(3900);
		chk_up(1'b1);
		ms(200);
		chk("rail_off_reset", 8'h01, {7'h00, pwr.system_rail_off});
		chk("switch_reset", 8'h00, {7'h00, pwr.battery_switch_on});
		rd_reg(shelf_pkg::ADDR_STATUS, d);
		chk("mode_reset", 8'h04, {5'h00, d[7:5]});
		@(posedge clk) press <= 1'b0;
		ms(800);
		chk("rail_off_hold", 8'h01, {7'h00, pwr.system_rail_off});
		chk("host_if_hold", 8'h01, {7'h00, pwr.host_if_ready});
		ms(400);
		chk_up(1'b1);
		test_done();
	end
endmodule : testbench
`default_nettype wire
